// ---- hdl/dsip_port.v ----
`include "dsip_defines.vh"
// one serial insertion port: requests bits, samples on falling edge, packs bytes
module dsip_port #(
    parameter NBYTES = 3
) (
    input  wire       clock_i,     // system clock
    input  wire       rst_n_i,     // sync reset, active low
    input  wire       rise_i,      // port clock rising edge pulse
    input  wire       fall_i,      // port clock falling edge pulse
    input  wire       frame_i,     // start of byte slots of a frame
    input  wire       ser_i,       // synchronised serial data
    output reg        req_o,       // bit request
    output reg  [7:0] byte_o,      // assembled byte
    output reg  [7:0] idx_o,       // byte position in group
    output reg        byte_vld_o   // byte ready pulse
);
    reg [7:0] bits_left_r;
    reg [7:0] bitcnt_r;
    reg [7:0] bytecnt_r;
    reg [7:0] shift_r;
    reg       pend_r;
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            req_o       <= 1'b0;
            byte_o      <= 8'h00;
            idx_o       <= 8'h00;
            byte_vld_o  <= 1'b0;
            bits_left_r <= 8'h00;
            bitcnt_r    <= 8'h00;
            bytecnt_r   <= 8'h00;
            shift_r     <= 8'h00;
            pend_r      <= 1'b0;
        end else begin
            byte_vld_o <= 1'b0;
            if (frame_i) begin
                bits_left_r <= NBYTES[7:0] * `DSIP_BITS_PER_BYTE;
                bitcnt_r    <= 8'h00;
                bytecnt_r   <= 8'h00;
                // no bit is taken in this period, so no request may stand in it
                req_o       <= 1'b0;
                pend_r      <= 1'b0;
            end else if (rise_i) begin
                // one period high per bit requested
                req_o <= (bits_left_r != 8'h00);
                pend_r <= (bits_left_r != 8'h00);
                if (bits_left_r != 8'h00)
                    bits_left_r <= bits_left_r - 8'h01;
            end else if (fall_i && pend_r) begin
                pend_r  <= 1'b0;
                // exactly one bit taken per request, msb first
                shift_r <= {shift_r[6:0], ser_i};
                if (bitcnt_r == `DSIP_BITS_PER_BYTE - 8'h01) begin
                    bitcnt_r   <= 8'h00;
                    byte_o     <= {shift_r[6:0], ser_i};
                    idx_o      <= bytecnt_r;
                    byte_vld_o <= 1'b1;
                    bytecnt_r  <= bytecnt_r + 8'h01;
                end else begin
                    bitcnt_r <= bitcnt_r + 8'h01;
                end
            end
        end
    end
endmodule // dsip_port

// ---- hdl/dsip_top.v ----
`include "dsip_defines.vh"
// Contract
// - line dcc request output, overhead clock output, line serial input provided
// - line serial bits placed into bytes D4..D12 of outgoing stream
// - line serial input sampled at overhead clock falling edge
// - section dcc request output with overhead clock and section serial input
// - section serial bits placed into bytes D1..D3 of outgoing stream
// - section serial input sampled at overhead clock falling edge
module dsip_top (
    input  wire       clock_i,                    // 50 MHz system clock
    input  wire       rst_n_i,                    // sync reset, active low
    input  wire       frame_start_i,              // frame dcc slot start pulse
    input  wire       line_dcc_serial_in_i,       // line dcc data pin
    input  wire       section_dcc_serial_in_i,    // section dcc data pin
    output reg        overhead_port_clock_o,      // shared port clock
    output reg        line_dcc_bit_request_o,     // line bit request
    output reg        section_dcc_bit_request_o,  // section bit request
    output reg  [7:0] dcc_byte_o,                 // byte to insert
    output reg  [3:0] dcc_slot_o,                 // 1..12 = D1..D12
    output reg        dcc_byte_vld_o              // insert strobe pulse
);
    reg  [7:0] div_r;
    reg        rise_r;
    reg        fall_r;
    reg        frame_pend_r;
    reg        l_s1_r, l_s2_r, s_s1_r, s_s2_r;
    wire       l_req, s_req, l_vld, s_vld;
    wire [7:0] l_byte, s_byte, l_idx, s_idx;

    // serial data pins from outside pass two flops
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            l_s1_r <= 1'b0;
            l_s2_r <= 1'b0;
            s_s1_r <= 1'b0;
            s_s2_r <= 1'b0;
        end else begin
            l_s1_r <= line_dcc_serial_in_i;
            l_s2_r <= l_s1_r;
            s_s1_r <= section_dcc_serial_in_i;
            s_s2_r <= s_s1_r;
        end
    end

    // port clock divider; frame start waits for a rising edge so requests align
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            div_r                 <= 8'h00;
            overhead_port_clock_o <= 1'b0;
            rise_r                <= 1'b0;
            fall_r                <= 1'b0;
            frame_pend_r          <= 1'b0;
        end else begin
            rise_r <= 1'b0;
            fall_r <= 1'b0;
            if (frame_start_i)
                frame_pend_r <= 1'b1;
            else if (rise_r)
                frame_pend_r <= 1'b0;
            if (div_r == `DSIP_CLK_HALF_DIV - 8'h01) begin
                div_r                 <= 8'h00;
                overhead_port_clock_o <= ~overhead_port_clock_o;
                rise_r                <= ~overhead_port_clock_o;
                fall_r                <= overhead_port_clock_o;
            end else begin
                div_r <= div_r + 8'h01;
            end
        end
    end

    // sync latency leaves data settled well before the falling edge sample
    dsip_port #(.NBYTES(`DSIP_SDCC_BYTES)) u_sdcc (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .rise_i     (rise_r),
        .fall_i     (fall_r),
        .frame_i    (frame_pend_r && rise_r),
        .ser_i      (s_s2_r),
        .req_o      (s_req),
        .byte_o     (s_byte),
        .idx_o      (s_idx),
        .byte_vld_o (s_vld)
    );

    dsip_port #(.NBYTES(`DSIP_LDCC_BYTES)) u_ldcc (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .rise_i     (rise_r),
        .fall_i     (fall_r),
        .frame_i    (frame_pend_r && rise_r),
        .ser_i      (l_s2_r),
        .req_o      (l_req),
        .byte_o     (l_byte),
        .idx_o      (l_idx),
        .byte_vld_o (l_vld)
    );

    // section bytes finish on the same falling edge as the first three line bytes, so section goes first
    // and line waits one cycle in a one-byte hold register
    reg        l_hold_r;
    reg  [7:0] l_hold_byte_r;
    reg  [7:0] l_hold_idx_r;
    wire [7:0] l_slot = l_hold_idx_r + `DSIP_SDCC_BYTES + 8'h01; // low nibble is the slot
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            line_dcc_bit_request_o    <= 1'b0;
            section_dcc_bit_request_o <= 1'b0;
            dcc_byte_o                <= 8'h00;
            dcc_slot_o                <= 4'h0;
            dcc_byte_vld_o            <= 1'b0;
            l_hold_r                  <= 1'b0;
            l_hold_byte_r             <= 8'h00;
            l_hold_idx_r              <= 8'h00;
        end else begin
            line_dcc_bit_request_o    <= l_req;
            section_dcc_bit_request_o <= s_req;
            dcc_byte_vld_o            <= 1'b0;
            if (l_vld) begin
                l_hold_r      <= 1'b1;
                l_hold_byte_r <= l_byte;
                l_hold_idx_r  <= l_idx;
            end
            if (s_vld) begin
                dcc_byte_o     <= s_byte;
                dcc_slot_o     <= s_idx[3:0] + 4'h1;
                dcc_byte_vld_o <= 1'b1;
            end else if (l_hold_r && !l_vld) begin
                l_hold_r       <= 1'b0;
                dcc_byte_o     <= l_hold_byte_r;
                dcc_slot_o     <= l_slot[3:0];
                dcc_byte_vld_o <= 1'b1;
            end
        end
    end
endmodule // dsip_top

// ---- shared/dsip_defines.vh ----
`ifndef DSIP_DEFINES_VH
`define DSIP_DEFINES_VH
// overhead clock divider: 50 MHz / 16 -> 3.125 MHz port clock
`define DSIP_CLK_HALF_DIV   8'h08
`define DSIP_DIV_W          8
// section dcc: 3 bytes, line dcc: 9 bytes, per frame
`define DSIP_SDCC_BYTES     8'h03
`define DSIP_LDCC_BYTES     8'h09
`define DSIP_BITS_PER_BYTE  8'h08
`define DSIP_CNT_W          8
`endif

// ---- sim/dsip_ctl_model.sv ----
module dsip_ctl_model #(parameter int NBITS = 24) (
    input  wire logic             clock_i,     // samples the port clock
    input  wire logic             port_clk_i,  // device port clock
    input  wire logic             req_i,       // device bit request
    input  wire logic [NBITS-1:0] data_i,      // bits, msb first
    output logic                  ser_o        // serial data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic go_q = 1'b0;
    int   idx = 0;
    initial ser_o = 1'b0;
    // idle pin toggles so a stale bit can never pass for data
    always @(negedge clock_i) begin
        go_q <= req_i & port_clk_i;
        if (!req_i) begin
            idx <= 0;
            ser_o <= ~ser_o;
        end else if (port_clk_i && !go_q) begin
            ser_o <= (idx < NBITS) ? data_i[NBITS - 1 - idx] : ~ser_o;
            idx <= idx + 1;
        end
    end
endmodule // dsip_ctl_model

// ---- sim/dsip_props.sv ----
module dsip_props (
    input wire logic       clock_i,                    // system clock
    input wire logic       rst_n_i,                    // sync reset
    input wire logic       overhead_port_clock_o,      // port clock
    input wire logic       line_dcc_bit_request_o,     // line request
    input wire logic       section_dcc_bit_request_o,  // section request
    input wire logic [3:0] dcc_slot_o,                 // byte slot
    input wire logic       dcc_byte_vld_o              // byte strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    wire         pc = overhead_port_clock_o;
    wire         lr = line_dcc_bit_request_o;
    wire         sr = section_dcc_bit_request_o;
    wire         v  = dcc_byte_vld_o;
    logic [11:0] l_cnt_r;
    logic [11:0] s_cnt_r;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    always @(posedge clock_i) begin
        l_cnt_r <= (rst_n_i && lr) ? l_cnt_r + 12'h001 : 12'h000;
        s_cnt_r <= (rst_n_i && sr) ? s_cnt_r + 12'h001 : 12'h000;
    end
    a_clk_high: assert property ($rose(pc) |-> pc [*8] ##1 !pc) else $error("clock high phase");
    a_clk_low: assert property ($fell(pc) |-> !pc [*8] ##1 pc) else $error("clock low phase");
    a_line_len: assert property ($fell(lr) |-> l_cnt_r == 12'h480) else $error("line request length");
    a_sec_len: assert property ($fell(sr) |-> s_cnt_r == 12'h180) else $error("section request length");
    a_line_phase: assert property ($changed(lr) |-> pc) else $error("line request phase");
    a_sec_phase: assert property ($changed(sr) |-> pc) else $error("section request phase");
    a_slot_range: assert property (v |-> dcc_slot_o inside {[4'h1:4'hc]}) else $error("slot range");
    a_sec_pair: assert property (v && dcc_slot_o <= 4'h3 |=> v && dcc_slot_o == $past(dcc_slot_o) + 4'h3)
        else $error("slot pairing");
    c_last: cover property (v && dcc_slot_o == 4'hc);
    c_sec: cover property ($fell(sr));
    c_line: cover property ($fell(lr));
endmodule // dsip_props

// ---- sim/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        frame_start_i = 1'b0;
    logic [23:0] sec_d = '0;
    logic [71:0] line_d = '0;
    wire         pclk, lreq, sreq, ldi, sdi, vld;
    wire  [7:0]  dbyte;
    wire  [3:0]  slot;
    int          fails = 0;
    int          total_checks = 0;
    int          got = 0;
    initial forever #10 clock_i = ~clock_i;
    dsip_top u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .frame_start_i(frame_start_i),
        .line_dcc_serial_in_i(ldi), .section_dcc_serial_in_i(sdi), .overhead_port_clock_o(pclk),
        .line_dcc_bit_request_o(lreq), .section_dcc_bit_request_o(sreq), .dcc_byte_o(dbyte),
        .dcc_slot_o(slot), .dcc_byte_vld_o(vld));
    dsip_ctl_model #(.NBITS(24)) u_sec (.clock_i(clock_i), .port_clk_i(pclk), .req_i(sreq),
        .data_i(sec_d), .ser_o(sdi));
    dsip_ctl_model #(.NBITS(72)) u_line (.clock_i(clock_i), .port_clk_i(pclk), .req_i(lreq),
        .data_i(line_d), .ser_o(ldi));
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function logic [7:0] exp_byte(input logic [3:0] s);
        return (s <= 4'h3) ? sec_d[(3 - s) * 8 +: 8] : line_d[(12 - s) * 8 +: 8];
    endfunction
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(negedge clock_i) if (vld === 1'b1) begin
        check("dcc byte", dbyte, exp_byte(slot));
        got++;
    end
    initial begin
        void'($urandom(99951));
        repeat (4) @(negedge clock_i);
        rst_n_i = 1'b1;
        // two fixed-level corners, then random groups back to back
        for (int f = 0; f < 6; f++) begin
            if (f == 0)
                {sec_d, line_d} = {24'h000000, {9{8'hff}}};
            else if (f == 1)
                {sec_d, line_d} = {24'hffffff, {9{8'h00}}};
            else
                {sec_d, line_d} = 96'({$urandom, $urandom, $urandom});
            got = 0;
            @(negedge clock_i) frame_start_i = 1'b1;
            @(negedge clock_i) frame_start_i = 1'b0;
            for (int n = 0; n < 1600 && got < 12; n++) @(negedge clock_i);
            check("byte count", 8'(got), 8'h0c);
        end
        summarize();
    end
    initial begin
        #250000;
        fails++;
        summarize();
    end
endmodule // tb_top
bind dsip_top dsip_props u_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .overhead_port_clock_o(overhead_port_clock_o), .line_dcc_bit_request_o(line_dcc_bit_request_o),
    .section_dcc_bit_request_o(section_dcc_bit_request_o), .dcc_slot_o(dcc_slot_o),
    .dcc_byte_vld_o(dcc_byte_vld_o));
